// ===== rtl/smcsr_pkg.sv
package smcsr_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam logic [4:0]  ADDR_LINK_CONTROL = 5'h00;
    localparam logic [4:0]  ADDR_LINK_STATUS  = 5'h01;

    ////////////////////////////////////////////////////////////////////////
    // Control field positions
    localparam int          CTL_POWER_DOWN    = 11;
    localparam int          CTL_ISOLATE       = 10;
    localparam int          CTL_RESTART_NEG   = 9;
    localparam int          CTL_DUPLEX        = 8;
    localparam int          CTL_COL_TEST      = 7;
    localparam int          CTL_SPEED_MSB     = 6;
    localparam int          CTL_UNIDIR_EN     = 5;

    // Control and link-latch reset values
    localparam logic        RST_POWER_DOWN    = 1'b0;
    localparam logic        RST_ISOLATE       = 1'b1;
    localparam logic        RST_SPEED_MSB     = 1'b1;
    localparam logic        RST_UNIDIR_EN     = 1'b0;
    localparam logic        RST_LINK_LATCH    = 1'b0;

    // Status field positions and constant content
    localparam int          STS_LINK          = 2;
    localparam logic [15:0] STS_CONST         = 16'h01C0;

    ////////////////////////////////////////////////////////////////////////
    // Management frame layout
    localparam logic [1:0]  OP_WRITE          = 2'h1;
    localparam logic [1:0]  OP_READ           = 2'h2;
    localparam logic [4:0]  HDR_LAST          = 5'h0B;
    localparam logic [4:0]  DATA_LAST         = 5'h0F;
    localparam logic [4:0]  TA_LAST           = 5'h01;
endpackage : smcsr_pkg

// ===== rtl/smcsr_regs.sv
`timescale 1ns/10ps
module smcsr_regs #(
    parameter bit HAS_XCVR = 1'b1
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic       i_lock_lost,
    input  wire logic       i_soft_rst,
    input  wire logic       i_ctrl_mode,
    input  wire logic [4:0] i_phy_addr,
    input  wire logic       i_link_up,
    input  wire logic       i_mdc,
    input  wire logic       i_mdio,
    output logic            o_mdio,
    output logic            o_mdio_oe,
    output logic            o_low_power,
    output logic            o_isolate,
    output logic            o_restart_neg,
    output logic            o_unidir_en
);
    typedef enum logic [2:0] {
        S_IDLE, S_START, S_HDR, S_TA, S_RDATA, S_WDATA
    } smcsr_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; a level counts once stages two and three agree
    logic [2:0]   mdc_sync_r;
    logic [2:0]   mdc_sync_nxt;
    logic [2:0]   mdio_sync_r;
    logic [2:0]   mdio_sync_nxt;
    logic         mdc_lvl_r;
    logic         mdc_lvl_nxt;
    logic         mdio_lvl_r;
    logic         mdio_lvl_nxt;
    logic         mdc_rise;

    always_comb begin
        mdc_sync_nxt  = {mdc_sync_r[1:0], i_mdc};
        mdio_sync_nxt = {mdio_sync_r[1:0], i_mdio};
        mdc_lvl_nxt   = mdc_lvl_r;
        mdio_lvl_nxt  = mdio_lvl_r;
        mdc_rise      = 1'b0;
        if (mdc_sync_r[1] == mdc_sync_r[2]) begin
            mdc_lvl_nxt = mdc_sync_r[2];
            mdc_rise    = mdc_sync_r[2] & ~mdc_lvl_r;
        end
        if (mdio_sync_r[1] == mdio_sync_r[2]) begin
            mdio_lvl_nxt = mdio_sync_r[2];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mdc_sync_r  <= 3'h0;
            mdio_sync_r <= 3'h7;
            mdc_lvl_r   <= 1'b0;
            mdio_lvl_r  <= 1'b1;
        end else if (i_ce) begin
            mdc_sync_r  <= mdc_sync_nxt;
            mdio_sync_r <= mdio_sync_nxt;
            mdc_lvl_r   <= mdc_lvl_nxt;
            mdio_lvl_r  <= mdio_lvl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame engine and register bank
    smcsr_state_t state_r;
    smcsr_state_t state_nxt;
    logic [4:0]   cnt_r;
    logic [4:0]   cnt_nxt;
    logic [15:0]  shift_r;
    logic [15:0]  shift_nxt;
    logic [1:0]   op_r;
    logic [1:0]   op_nxt;
    logic [4:0]   reg_addr_r;
    logic [4:0]   reg_addr_nxt;
    logic         match_r;
    logic         match_nxt;
    logic         mdio_r;
    logic         mdio_nxt;
    logic         mdio_oe_r;
    logic         mdio_oe_nxt;
    logic         pd_r;
    logic         pd_nxt;
    logic         iso_r;
    logic         iso_nxt;
    logic         spd_r;
    logic         spd_nxt;
    logic         uni_r;
    logic         uni_nxt;
    logic         restart_r;
    logic         restart_nxt;
    logic         link_r;
    logic         link_nxt;
    logic [15:0]  ctl_word;
    logic [15:0]  sts_word;
    logic [15:0]  rd_word;
    logic         core_rst;
    logic         wr_ctl;
    logic         rd_sts;

    assign core_rst = i_lock_lost | i_soft_rst;

    always_comb begin
        ctl_word = 16'h0000;
        ctl_word[smcsr_pkg::CTL_POWER_DOWN] = pd_r;
        ctl_word[smcsr_pkg::CTL_ISOLATE]    = iso_r;
        ctl_word[smcsr_pkg::CTL_DUPLEX]     = 1'b1;
        ctl_word[smcsr_pkg::CTL_SPEED_MSB]  =
            i_ctrl_mode ? spd_r : 1'b1;
        ctl_word[smcsr_pkg::CTL_UNIDIR_EN]  = uni_r;
        // Constants cover bits 15:3 and 1:0 of status
        sts_word = smcsr_pkg::STS_CONST;
        sts_word[smcsr_pkg::STS_LINK] = link_r;
        case (reg_addr_r)
            smcsr_pkg::ADDR_LINK_CONTROL: rd_word = ctl_word;
            smcsr_pkg::ADDR_LINK_STATUS:  rd_word = sts_word;
            default:                      rd_word = 16'h0000;
        endcase
    end

    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        shift_nxt    = shift_r;
        op_nxt       = op_r;
        reg_addr_nxt = reg_addr_r;
        match_nxt    = match_r;
        mdio_nxt     = mdio_r;
        mdio_oe_nxt  = mdio_oe_r;
        wr_ctl       = 1'b0;
        rd_sts       = 1'b0;
        if (mdc_rise) begin
            case (state_r)
                S_IDLE: begin
                    // Preamble may be suppressed, so any zero starts a frame
                    if (!mdio_lvl_r) begin
                        state_nxt = S_START;
                    end
                end
                S_START: begin
                    state_nxt = mdio_lvl_r ? S_HDR : S_IDLE;
                    cnt_nxt   = 5'h00;
                end
                S_HDR: begin
                    shift_nxt = {shift_r[14:0], mdio_lvl_r};
                    cnt_nxt   = cnt_r + 5'h01;
                    if (cnt_r == smcsr_pkg::HDR_LAST) begin
                        op_nxt       = shift_r[10:9];
                        reg_addr_nxt = {shift_r[3:0], mdio_lvl_r};
                        match_nxt    = (shift_r[8:4] == i_phy_addr);
                        cnt_nxt      = 5'h00;
                        state_nxt    = S_TA;
                    end
                end
                S_TA: begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == 5'h00) begin
                        if (match_r && op_r == smcsr_pkg::OP_READ) begin
                            mdio_nxt    = 1'b0;
                            mdio_oe_nxt = 1'b1;
                        end
                    end else if (cnt_r == smcsr_pkg::TA_LAST) begin
                        cnt_nxt = 5'h00;
                        if (mdio_oe_r) begin
                            shift_nxt = {rd_word[14:0], 1'b0};
                            mdio_nxt  = rd_word[15];
                            state_nxt = S_RDATA;
                            rd_sts    = (reg_addr_r ==
                                         smcsr_pkg::ADDR_LINK_STATUS);
                        end else begin
                            state_nxt = S_WDATA;
                        end
                    end
                end
                S_RDATA: begin
                    cnt_nxt   = cnt_r + 5'h01;
                    mdio_nxt  = shift_r[15];
                    shift_nxt = {shift_r[14:0], 1'b0};
                    if (cnt_r == smcsr_pkg::DATA_LAST) begin
                        mdio_nxt    = 1'b1;
                        mdio_oe_nxt = 1'b0;
                        state_nxt   = S_IDLE;
                    end
                end
                S_WDATA: begin
                    cnt_nxt   = cnt_r + 5'h01;
                    shift_nxt = {shift_r[14:0], mdio_lvl_r};
                    if (cnt_r == smcsr_pkg::DATA_LAST) begin
                        // Status and unmapped writes fall through unused
                        wr_ctl = match_r && op_r == smcsr_pkg::OP_WRITE &&
                                 reg_addr_r ==
                                 smcsr_pkg::ADDR_LINK_CONTROL;
                        state_nxt = S_IDLE;
                    end
                end
                default: begin
                    state_nxt   = S_IDLE;
                    mdio_oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // Control and status bank
    logic [15:0] wr_word;

    always_comb begin
        wr_word     = {shift_r[14:0], mdio_lvl_r};
        pd_nxt      = pd_r;
        iso_nxt     = iso_r;
        spd_nxt     = spd_r;
        uni_nxt     = uni_r;
        restart_nxt = 1'b0;
        if (wr_ctl) begin
            pd_nxt      = pd_r | wr_word[smcsr_pkg::CTL_POWER_DOWN];
            iso_nxt     = wr_word[smcsr_pkg::CTL_ISOLATE];
            uni_nxt     = wr_word[smcsr_pkg::CTL_UNIDIR_EN];
            restart_nxt = wr_word[smcsr_pkg::CTL_RESTART_NEG];
            if (i_ctrl_mode) begin
                spd_nxt = wr_word[smcsr_pkg::CTL_SPEED_MSB];
            end
        end
        // A drop in the same cycle as the reload still latches zero
        if (rd_sts) begin
            link_nxt = i_link_up;
        end else begin
            link_nxt = link_r & i_link_up;
        end
        if (!i_link_up) begin
            link_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r       <= S_IDLE;
            cnt_r         <= 5'h00;
            shift_r       <= 16'h0000;
            op_r          <= 2'h0;
            reg_addr_r    <= 5'h00;
            match_r       <= 1'b0;
            mdio_r        <= 1'b1;
            mdio_oe_r     <= 1'b0;
            pd_r          <= smcsr_pkg::RST_POWER_DOWN;
            iso_r         <= smcsr_pkg::RST_ISOLATE;
            spd_r         <= smcsr_pkg::RST_SPEED_MSB;
            uni_r         <= smcsr_pkg::RST_UNIDIR_EN;
            restart_r     <= 1'b0;
            link_r        <= smcsr_pkg::RST_LINK_LATCH;
            o_low_power   <= 1'b0;
            o_isolate     <= smcsr_pkg::RST_ISOLATE;
            o_unidir_en   <= smcsr_pkg::RST_UNIDIR_EN;
        end else if (i_ce) begin
            state_r       <= state_nxt;
            cnt_r         <= cnt_nxt;
            shift_r       <= shift_nxt;
            op_r          <= op_nxt;
            reg_addr_r    <= reg_addr_nxt;
            match_r       <= match_nxt;
            mdio_r        <= mdio_nxt;
            mdio_oe_r     <= mdio_oe_nxt;
            if (core_rst) begin
                // Synchronous core resets restore defaults like i_rst
                pd_r        <= smcsr_pkg::RST_POWER_DOWN;
                iso_r       <= smcsr_pkg::RST_ISOLATE;
                spd_r       <= smcsr_pkg::RST_SPEED_MSB;
                uni_r       <= smcsr_pkg::RST_UNIDIR_EN;
                restart_r   <= 1'b0;
                link_r      <= smcsr_pkg::RST_LINK_LATCH;
                o_low_power <= 1'b0;
                o_isolate   <= smcsr_pkg::RST_ISOLATE;
                o_unidir_en <= smcsr_pkg::RST_UNIDIR_EN;
            end else begin
                pd_r        <= pd_nxt;
                iso_r       <= iso_nxt;
                spd_r       <= spd_nxt;
                uni_r       <= uni_nxt;
                restart_r   <= restart_nxt;
                link_r      <= link_nxt;
                o_low_power <= pd_nxt & HAS_XCVR;
                o_isolate   <= iso_nxt;
                o_unidir_en <= uni_nxt;
            end
        end
    end

    assign o_mdio        = mdio_r;
    assign o_mdio_oe     = mdio_oe_r;
    assign o_restart_neg = restart_r;
endmodule : smcsr_regs

// ===== tb/smcsr_regs_assertions.sv
`timescale 1ns/10ps
module smcsr_regs_chk (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_ce,
    input wire logic       i_lock_lost,
    input wire logic       i_soft_rst,
    input wire logic       i_ctrl_mode,
    input wire logic [4:0] i_phy_addr,
    input wire logic       i_link_up,
    input wire logic       i_mdc,
    input wire logic       i_mdio,
    input wire logic       o_mdio,
    input wire logic       o_mdio_oe,
    input wire logic       o_low_power,
    input wire logic       o_isolate,
    input wire logic       o_restart_neg,
    input wire logic       o_unidir_en
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////
    pd_sticky_a: assert property ($fell(o_low_power) |->
        $past(i_lock_lost) || $past(i_soft_rst)) else $error("power down lost");
    restart_pulse_a: assert property (o_restart_neg |=>
        !o_restart_neg) else $error("restart pulse too long");
    core_reset_a: assert property ((i_lock_lost || i_soft_rst) && i_ce
        |=> o_isolate && !o_low_power && !o_unidir_en)
        else $error("core reset left control bits");
    rel_defaults_a: assert property ($fell(i_rst) |->
        o_isolate && !o_low_power && !o_unidir_en)
        else $error("wrong outputs after reset");
    ta_zero_a: assert property ($rose(o_mdio_oe) |-> !o_mdio)
        else $error("turnaround bit not zero");
    drive_len_a: assert property ($rose(o_mdio_oe) |=>
        o_mdio_oe [*8]) else $error("read drive cut short");
    idle_high_a: assert property (!o_mdio_oe |-> o_mdio)
        else $error("data output not high while idle");
    iso_quiet_a: assert property ($changed(o_isolate) |->
        !o_mdio_oe) else $error("isolate moved during a read");
    // Main scenarios seen
    cover property (o_restart_neg);
    cover property ($rose(o_mdio_oe));
    cover property ($rose(o_low_power));
endmodule : smcsr_regs_chk

bind smcsr_regs smcsr_regs_chk u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_lock_lost(i_lock_lost),
    .i_soft_rst(i_soft_rst), .i_ctrl_mode(i_ctrl_mode),
    .i_phy_addr(i_phy_addr), .i_link_up(i_link_up), .i_mdc(i_mdc),
    .i_mdio(i_mdio), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
    .o_low_power(o_low_power), .o_isolate(o_isolate),
    .o_restart_neg(o_restart_neg), .o_unidir_en(o_unidir_en)
);

// ===== tb/smcsr_regs_tb.sv
`timescale 1ns/10ps
module smcsr_regs_tb;
    localparam logic [4:0] PHY = 5'h03;
    localparam logic [4:0] CTL = smcsr_pkg::ADDR_LINK_CONTROL;
    localparam logic [4:0] STS = smcsr_pkg::ADDR_LINK_STATUS;
    logic i_clk, i_rst, i_lock_lost, i_soft_rst, i_ctrl_mode, i_link_up;
    logic i_mdc, st_mdio, mdio_w, o_mdio, o_mdio_oe;
    logic o_low_power, o_isolate, o_restart_neg, o_unidir_en;
    logic tbi_low_power;
    logic [15:0] q;
    int   error_cnt, comparisons, pulses, cyc;
    // Pull-up wins whenever nobody drives
    assign mdio_w = o_mdio_oe ? o_mdio : st_mdio;
    smcsr_regs dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_lock_lost(i_lock_lost),
        .i_soft_rst(i_soft_rst), .i_ctrl_mode(i_ctrl_mode),
        .i_phy_addr(PHY), .i_link_up(i_link_up), .i_mdc(i_mdc),
        .i_mdio(mdio_w), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
        .o_low_power(o_low_power), .o_isolate(o_isolate),
        .o_restart_neg(o_restart_neg), .o_unidir_en(o_unidir_en));
    // Ten-bit-interface variant follows the same frames, never drives
    smcsr_regs #(.HAS_XCVR(1'b0)) dut_tbi (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_lock_lost(i_lock_lost),
        .i_soft_rst(i_soft_rst), .i_ctrl_mode(i_ctrl_mode),
        .i_phy_addr(PHY), .i_link_up(i_link_up), .i_mdc(i_mdc),
        .i_mdio(mdio_w), .o_mdio(), .o_mdio_oe(),
        .o_low_power(tbi_low_power), .o_isolate(), .o_restart_neg(),
        .o_unidir_en());
    smcsr_station st (.i_clk(i_clk), .i_wire(mdio_w), .o_mdc(i_mdc),
                      .o_mdio(st_mdio));
    always #4 i_clk = ~i_clk;
    // Pulse counted mid-cycle, clear of the edge that launches it
    always @(negedge i_clk) begin
        if (o_restart_neg === 1'b1) pulses++;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk1
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        st.frame(1'b0, PHY, ra, wd, q);
    endtask : wr
    task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
        st.frame(1'b1, PHY, ra, 16'h0000, q);
        chk16(q, exp);
    endtask : rd_chk
    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        chk1(o_isolate, 1'b1);
        chk1(o_unidir_en, 1'b0);
        rd_chk(CTL, 16'h0540);
        rd_chk(STS, 16'h01C0);
        rd_chk(STS, 16'h01C4);
    endtask : t_defaults
    task automatic t_control();
        wr(CTL, 16'hFFFF);
        chk1(pulses == 1, 1'b1);
        chk1(o_low_power, 1'b1);
        chk1(tbi_low_power, 1'b0);
        chk1(o_unidir_en, 1'b1);
        rd_chk(CTL, 16'h0D60);
        i_ctrl_mode <= 1'b1;
        wr(CTL, 16'h0000);
        rd_chk(CTL, 16'h0900);
        chk1(o_isolate, 1'b0);
        chk1(o_low_power, 1'b1);
        chk1(pulses == 1, 1'b1);
        i_ctrl_mode <= 1'b0;
        rd_chk(CTL, 16'h0940);
    endtask : t_control
    task automatic t_link();
        @(posedge i_clk) i_link_up <= 1'b0;
        @(posedge i_clk) i_link_up <= 1'b1;
        rd_chk(STS, 16'h01C0);
        rd_chk(STS, 16'h01C4);
        wr(STS, 16'hFFFF);
        rd_chk(STS, 16'h01C4);
        wr(5'h05, 16'hFFFF);
        rd_chk(5'h05, 16'h0000);
        rd_chk(CTL, 16'h0940);
    endtask : t_link
    task automatic t_resets();
        // Write costs a whole frame, so each source gets one pass
        for (int k = 0; k < 2; k++) begin
            wr(CTL, 16'hFFFF);
            @(posedge i_clk);
            if (k == 0) i_lock_lost <= 1'b1;
            else i_soft_rst <= 1'b1;
            @(posedge i_clk);
            i_lock_lost <= 1'b0;
            i_soft_rst  <= 1'b0;
            rd_chk(CTL, 16'h0540);
            chk1(o_low_power, 1'b0);
        end
        wr(CTL, 16'hFFFF);
        @(posedge i_clk) i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        rd_chk(CTL, 16'h0540);
        rd_chk(STS, 16'h01C0);
    endtask : t_resets
    initial begin
        i_clk = 1'b0;
        i_rst = 1'b1;
        i_lock_lost = 1'b0;
        i_soft_rst = 1'b0;
        i_ctrl_mode = 1'b0;
        i_link_up = 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        t_defaults();
        t_control();
        t_link();
        t_resets();
        close_out();
    end
endmodule : smcsr_regs_tb

// ===== tb/smcsr_station.sv
`timescale 1ns/10ps
module smcsr_station (
    input  wire logic i_clk,
    input  wire logic i_wire,
    output logic      o_mdc,
    output logic      o_mdio
);
    // Phases kept above the three-cycle synchroniser minimum
    localparam int HALF = 5;
    initial begin
        o_mdc  = 1'b0;
        o_mdio = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic bit_cyc(input logic drv, input logic val, output logic s);
        @(posedge i_clk);
        o_mdio <= drv ? val : 1'b1;
        repeat (HALF) @(posedge i_clk);
        s = i_wire;
        o_mdc <= 1'b1;
        repeat (HALF) @(posedge i_clk);
        o_mdc <= 1'b0;
    endtask : bit_cyc
    // Clock stands low between frames; released line idles high
    task automatic frame(input logic rd, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] q);
        logic [31:0] w;
        logic        s;
        w = {2'b01, rd ? smcsr_pkg::OP_READ : smcsr_pkg::OP_WRITE,
             pa, ra, 2'b10, wd};
        for (int i = 31; i >= 0; i--) begin
            bit_cyc(!(rd && i < 18), w[i], s);
            if (i < 16) q[i] = s;
        end
        @(posedge i_clk);
        o_mdio <= 1'b1;
        repeat (12) @(posedge i_clk);
    endtask : frame
endmodule : smcsr_station
